// ===== src/ssq_pkg.sv
// package: constants and carrier types for the sensor sample queue port
package ssq_pkg;

   // ---------------------------------------------------------------
   // bus and register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W       = 10;
   localparam logic [7:0]  IDX_SRC_EN   = 8'h23;
   localparam logic [7:0]  IDX_AUX_CTRL = 8'h24;
   localparam logic [7:0]  IDX_INT_MASK = 8'h39;
   localparam logic [7:0]  IDX_INT_STAT = 8'h3a;
   localparam logic [7:0]  IDX_CNT_HI   = 8'h72;
   localparam logic [7:0]  IDX_CNT_LO   = 8'h73;
   localparam logic [7:0]  IDX_DATA     = 8'h74;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   // ---------------------------------------------------------------
   // queue geometry
   // ---------------------------------------------------------------
   localparam int unsigned PTR_W   = 10;
   localparam logic [15:0] CNT_MAX = 16'h0400;

   // ---------------------------------------------------------------
   // sensor byte groups: byte i of the frame is data register 59 + i
   // ---------------------------------------------------------------
   localparam logic [5:0] LAST_IDX = 6'h25;
   localparam logic [5:0] ACC_END  = 6'h06;
   localparam logic [5:0] TMP_END  = 6'h08;
   localparam logic [5:0] GX_END   = 6'h0a;
   localparam logic [5:0] GY_END   = 6'h0c;
   localparam logic [5:0] GZ_END   = 6'h0e;
   localparam logic [5:0] S0_END   = 6'h14;
   localparam logic [5:0] S1_END   = 6'h1a;
   localparam logic [5:0] S2_END   = 6'h20;

   // source enable bits and the aux control slave 3 bit
   localparam int unsigned EN_TEMP  = 7;
   localparam int unsigned EN_XG    = 6;
   localparam int unsigned EN_YG    = 5;
   localparam int unsigned EN_ZG    = 4;
   localparam int unsigned EN_ACC   = 3;
   localparam int unsigned EN_SLV2  = 2;
   localparam int unsigned EN_SLV1  = 1;
   localparam int unsigned EN_SLV0  = 0;
   localparam int unsigned AUX_SLV3 = 5;

   // event status bits
   localparam int unsigned ST_OVF  = 0;
   localparam int unsigned ST_DONE = 1;
   localparam int unsigned NUM_EV  = 2;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic {
      SEQ_IDLE = 1'b0,
      SEQ_RUN  = 1'b1
   } ssq_seq_e;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } ssq_push_s;

endpackage : ssq_pkg

// ===== src/ssq_port.sv
// module: sensor sample byte queue with count shadow and data port
//
// Behaviour
// - keep 16-bit count of queued bytes
// - high count read loads both shadow bytes
// - low count read alone refreshes nothing
// - each tick while idle queues enabled bytes, ascending order
// - group queued only when its enable set
// - slave 3 bytes need aux control enable
// - overflow sets queue overflow status flag
// - overflow drops oldest byte, keeps new
// - empty read repeats last byte read
// - data port moves one byte per access
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module ssq_port (
   input  wire logic                       CLOCK,
   input  wire logic                       RSTN,
   input  wire logic                       SAMPLE_TICK,
   input  wire logic [303:0]               SENSOR_BYTES,
   input  wire logic                       S_AXI_AWVALID,
   output logic                            S_AXI_AWREADY,
   input  wire logic [ssq_pkg::ADDR_W-1:0] S_AXI_AWADDR,
   input  wire logic                       S_AXI_WVALID,
   output logic                            S_AXI_WREADY,
   input  wire logic [31:0]                S_AXI_WDATA,
   input  wire logic [3:0]                 S_AXI_WSTRB,
   output logic                            S_AXI_BVALID,
   input  wire logic                       S_AXI_BREADY,
   output logic [1:0]                      S_AXI_BRESP,
   input  wire logic                       S_AXI_ARVALID,
   output logic                            S_AXI_ARREADY,
   input  wire logic [ssq_pkg::ADDR_W-1:0] S_AXI_ARADDR,
   output logic                            S_AXI_RVALID,
   input  wire logic                       S_AXI_RREADY,
   output logic [31:0]                     S_AXI_RDATA,
   output logic [1:0]                      S_AXI_RRESP,
   output logic                            IRQ
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // group enable of frame byte i; slave 3 has its own flag
   function automatic logic byte_on(input logic [5:0] i,
                                    input logic [7:0] src,
                                    input logic [7:0] aux);
      logic r;
      if (i < ssq_pkg::ACC_END)      r = src[ssq_pkg::EN_ACC];
      else if (i < ssq_pkg::TMP_END) r = src[ssq_pkg::EN_TEMP];
      else if (i < ssq_pkg::GX_END)  r = src[ssq_pkg::EN_XG];
      else if (i < ssq_pkg::GY_END)  r = src[ssq_pkg::EN_YG];
      else if (i < ssq_pkg::GZ_END)  r = src[ssq_pkg::EN_ZG];
      else if (i < ssq_pkg::S0_END)  r = src[ssq_pkg::EN_SLV0];
      else if (i < ssq_pkg::S1_END)  r = src[ssq_pkg::EN_SLV1];
      else if (i < ssq_pkg::S2_END)  r = src[ssq_pkg::EN_SLV2];
      else                           r = aux[ssq_pkg::AUX_SLV3];
      return r;
   endfunction : byte_on

   function automatic logic mapped(input logic [7:0] i);
      return (i == ssq_pkg::IDX_SRC_EN)   || (i == ssq_pkg::IDX_AUX_CTRL) ||
             (i == ssq_pkg::IDX_INT_MASK) || (i == ssq_pkg::IDX_INT_STAT) ||
             (i == ssq_pkg::IDX_CNT_HI)   || (i == ssq_pkg::IDX_CNT_LO)   ||
             (i == ssq_pkg::IDX_DATA);
   endfunction : mapped

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [7:0]                  mem [0:ssq_pkg::CNT_MAX-1];
   logic [ssq_pkg::PTR_W-1:0]   wr_ptr_q, rd_ptr_q;
   logic [15:0]                 count_q, count_d, shadow_q;
   logic [7:0]                  last_q, src_en_q, aux_q;
   logic [ssq_pkg::NUM_EV-1:0]  mask_q, stat_q, stat_d, ev, clr;
   ssq_pkg::ssq_seq_e           seq_q;
   logic [5:0]                  seq_idx_q;
   logic                        bvalid_q, rvalid_q;
   logic [1:0]                  bresp_q, rresp_q;
   logic [31:0]                 rdata_q;

   logic                        wr_go, rd_go, bus_push, seq_push, seq_adv;
   logic                        pop, empty_rd, full, drop, seq_last;
   logic [7:0]                  wr_idx, rd_idx, seq_byte, head, rd_val;
   ssq_pkg::ssq_push_s          push;

   // ---------------------------------------------------------------
   // bus handshakes: write takes address and data in one edge
   // ---------------------------------------------------------------
   assign S_AXI_AWREADY = S_AXI_AWVALID && S_AXI_WVALID && !bvalid_q;
   assign S_AXI_WREADY  = S_AXI_AWREADY;
   assign S_AXI_ARREADY = !rvalid_q;
   assign wr_go         = S_AXI_AWREADY;
   assign rd_go         = S_AXI_ARVALID && !rvalid_q;
   assign wr_idx        = S_AXI_AWADDR[ssq_pkg::ADDR_W-1:2];
   assign rd_idx        = S_AXI_ARADDR[ssq_pkg::ADDR_W-1:2];
   assign S_AXI_BVALID  = bvalid_q;
   assign S_AXI_BRESP   = bresp_q;
   assign S_AXI_RVALID  = rvalid_q;
   assign S_AXI_RRESP   = rresp_q;
   assign S_AXI_RDATA   = rdata_q;

   // ---------------------------------------------------------------
   // queue push and pop decode
   // ---------------------------------------------------------------
   // a bus write to the port wins; the sequencer waits one cycle
   assign bus_push = wr_go && (wr_idx == ssq_pkg::IDX_DATA)
                     && S_AXI_WSTRB[0];
   assign seq_byte = SENSOR_BYTES[{seq_idx_q, 3'b000} +: 8];
   assign seq_adv  = (seq_q == ssq_pkg::SEQ_RUN) && !bus_push;
   assign seq_push = seq_adv
                     && byte_on(seq_idx_q, src_en_q, aux_q);
   assign seq_last = seq_idx_q == ssq_pkg::LAST_IDX;
   assign push.valid = bus_push || seq_push;
   assign push.data  = bus_push ? S_AXI_WDATA[7:0] : seq_byte;
   assign full     = count_q == ssq_pkg::CNT_MAX;
   assign head     = mem[rd_ptr_q];
   assign pop      = rd_go && (rd_idx == ssq_pkg::IDX_DATA)
                     && (count_q != 16'h0000);
   assign empty_rd = rd_go && (rd_idx == ssq_pkg::IDX_DATA)
                     && (count_q == 16'h0000);
   assign drop     = push.valid && full && !pop;

   // count: up on store, down on pop, held when full
   always_comb
   begin
      count_d = count_q;
      if (push.valid && !pop && !full)
         count_d = count_q + 16'h0001;
      else if (pop && !push.valid)
         count_d = count_q - 16'h0001;
   end

   // ---------------------------------------------------------------
   // queue storage; no reset so it maps onto ram
   // ---------------------------------------------------------------
   always_ff @(posedge CLOCK)
   begin
      if (push.valid)
         mem[wr_ptr_q] <= push.data;
   end

   // pointers, count, last byte read and shadow of the count
   always_ff @(posedge CLOCK)
   begin
      if (!RSTN)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= 16'h0000;
         last_q   <= 8'h00;
         shadow_q <= 16'h0000;
      end
      else
      begin
         count_q <= count_d;
         if (push.valid)
            wr_ptr_q <= wr_ptr_q + 1'b1;
         if (pop || drop)
            rd_ptr_q <= rd_ptr_q + 1'b1;
         if (pop)
            last_q <= head;
         if (rd_go && (rd_idx == ssq_pkg::IDX_CNT_HI))
            shadow_q <= count_q;
      end
   end

   // ---------------------------------------------------------------
   // sampling sequencer: walks frame bytes in register order
   // ---------------------------------------------------------------
   // limitation: SENSOR_BYTES must hold still for the 38-cycle walk;
   // a tick arriving mid-walk is ignored
   always_ff @(posedge CLOCK)
   begin
      if (!RSTN)
      begin
         seq_q     <= ssq_pkg::SEQ_IDLE;
         seq_idx_q <= 6'h00;
      end
      else
      begin
         case (seq_q)
            ssq_pkg::SEQ_IDLE:
            begin
               seq_idx_q <= 6'h00;
               if (SAMPLE_TICK)
                  seq_q <= ssq_pkg::SEQ_RUN;
            end
            ssq_pkg::SEQ_RUN:
            begin
               if (seq_adv && seq_last)
                  seq_q <= ssq_pkg::SEQ_IDLE;
               else if (seq_adv)
                  seq_idx_q <= seq_idx_q + 6'h01;
            end
            default:
               seq_q <= ssq_pkg::SEQ_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // events and interrupt: set beats a write-one clear
   // ---------------------------------------------------------------
   assign ev[ssq_pkg::ST_OVF]  = drop;
   assign ev[ssq_pkg::ST_DONE] = seq_adv && seq_last;
   // a write with byte lane 0 off clears nothing, like every other register
   assign clr    = (wr_go && S_AXI_WSTRB[0] && (wr_idx == ssq_pkg::IDX_INT_STAT))
                   ? S_AXI_WDATA[ssq_pkg::NUM_EV-1:0] : '0;
   assign stat_d = (stat_q & ~clr) | ev;
   assign IRQ    = |(stat_q & mask_q);

   // ---------------------------------------------------------------
   // software registers and bus answers
   // ---------------------------------------------------------------
   // read mux; high count answers the live count it is latching
   always_comb
   begin
      case (rd_idx)
         ssq_pkg::IDX_SRC_EN:   rd_val = src_en_q;
         ssq_pkg::IDX_AUX_CTRL: rd_val = aux_q;
         ssq_pkg::IDX_INT_MASK: rd_val = {6'h00, mask_q};
         ssq_pkg::IDX_INT_STAT: rd_val = {6'h00, stat_q};
         ssq_pkg::IDX_CNT_HI:   rd_val = count_q[15:8];
         ssq_pkg::IDX_CNT_LO:   rd_val = shadow_q[7:0];
         ssq_pkg::IDX_DATA:     rd_val = empty_rd ? last_q : head;
         default:               rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge CLOCK)
   begin
      if (!RSTN)
      begin
         src_en_q <= 8'h00;
         aux_q    <= 8'h00;
         mask_q   <= '0;
         stat_q   <= '0;
         bvalid_q <= 1'b0;
         bresp_q  <= ssq_pkg::RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q  <= ssq_pkg::RESP_OKAY;
         rdata_q  <= 32'h0000_0000;
      end
      else
      begin
         stat_q <= stat_d;
         if (wr_go && S_AXI_WSTRB[0] && (wr_idx == ssq_pkg::IDX_SRC_EN))
            src_en_q <= S_AXI_WDATA[7:0];
         if (wr_go && S_AXI_WSTRB[0] && (wr_idx == ssq_pkg::IDX_AUX_CTRL))
            aux_q <= S_AXI_WDATA[7:0];
         if (wr_go && S_AXI_WSTRB[0] && (wr_idx == ssq_pkg::IDX_INT_MASK))
            mask_q <= S_AXI_WDATA[ssq_pkg::NUM_EV-1:0];
         if (wr_go)
         begin
            bvalid_q <= 1'b1;
            bresp_q  <= mapped(wr_idx) ? ssq_pkg::RESP_OKAY : ssq_pkg::RESP_SLVERR;
         end
         else if (S_AXI_BREADY)
            bvalid_q <= 1'b0;
         if (rd_go)
         begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h000000, rd_val};
            rresp_q  <= mapped(rd_idx) ? ssq_pkg::RESP_OKAY : ssq_pkg::RESP_SLVERR;
         end
         else if (S_AXI_RREADY)
            rvalid_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RSTN);

   chk_count_bound: assert property (
      count_q <= ssq_pkg::CNT_MAX)
      else $error("queue count above capacity");

   chk_shadow_load: assert property (
      rd_go && (rd_idx == ssq_pkg::IDX_CNT_HI) |=>
      (shadow_q == $past(count_q)) && (S_AXI_RDATA[7:0] == $past(count_q[15:8])))
      else $error("shadow not loaded on high count read");

   chk_low_keeps: assert property (
      rd_go && (rd_idx == ssq_pkg::IDX_CNT_LO) |=>
      $stable(shadow_q) && (S_AXI_RDATA[7:0] == shadow_q[7:0]))
      else $error("low count read disturbed shadow");

   chk_seq_order: assert property (
      seq_adv && !seq_last |=> seq_idx_q == $past(seq_idx_q) + 6'h01)
      else $error("sequencer skipped or repeated a byte");

   chk_src_gate: assert property (
      (seq_q == ssq_pkg::SEQ_RUN) && !byte_on(seq_idx_q, src_en_q, aux_q)
      |-> !push.valid || bus_push)
      else $error("disabled group was queued");

   chk_ovf_flag: assert property (
      drop |=> stat_q[ssq_pkg::ST_OVF])
      else $error("overflow did not set status");

   chk_drop_oldest: assert property (
      drop |=> (rd_ptr_q == $past(rd_ptr_q) + 1'b1) && $stable(count_q))
      else $error("overflow did not drop oldest byte");

   chk_empty_repeat: assert property (
      empty_rd |=> S_AXI_RVALID && (S_AXI_RDATA[7:0] == $past(last_q)))
      else $error("empty read did not repeat last byte");

   chk_pop_step: assert property (
      pop && !push.valid |=> count_q == $past(count_q) - 16'h0001)
      else $error("pop did not decrement count");

endmodule : ssq_port

`default_nettype wire

// ===== verif/ssq_host_model.sv
// host processor model: register master on the lite bus
`timescale 1ns/1ps
`default_nettype none

module ssq_host_model (
   input  wire logic        clock,
   output var  logic        awvalid,
   input  wire logic        awready,
   output var  logic [9:0]  awaddr,
   output var  logic        wvalid,
   input  wire logic        wready,
   output var  logic [31:0] wdata,
   output var  logic [3:0]  wstrb,
   input  wire logic        bvalid,
   output var  logic        bready,
   input  wire logic [1:0]  bresp,
   output var  logic        arvalid,
   input  wire logic        arready,
   output var  logic [9:0]  araddr,
   input  wire logic        rvalid,
   output var  logic        rready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp
);
   // idle bus at time zero
   initial
   begin
      awvalid = 1'b0;
      wvalid  = 1'b0;
      bready  = 1'b0;
      arvalid = 1'b0;
      rready  = 1'b0;
      awaddr  = 10'h000;
      araddr  = 10'h000;
      wdata   = 32'h0;
      wstrb   = 4'hf;
   end

   // -----------------------------------------------------------
   // bus cycles
   // -----------------------------------------------------------
   task automatic write_reg(input logic [7:0] idx, input logic [31:0] data,
                            output logic [1:0] resp);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done  = 1'b0;
      @(posedge clock);
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      awaddr  <= {idx, 2'b00};
      wdata   <= data;
      bready  <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(posedge clock);
         // released payload is scrambled so a stale value never looks valid
         if (!aw_done && awready)
         begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
            awaddr  <= ~awaddr;
         end
         if (!w_done && wready)
         begin
            w_done = 1'b1;
            wvalid <= 1'b0;
            wdata  <= ~wdata;
         end
      end
      while (!bvalid)
         @(posedge clock);
      resp = bresp;
      bready <= 1'b0;
   endtask : write_reg

   task automatic read_reg(input logic [7:0] idx, output logic [31:0] data,
                           output logic [1:0] resp);
      @(posedge clock);
      arvalid <= 1'b1;
      araddr  <= {idx, 2'b00};
      rready  <= 1'b1;
      do
         @(posedge clock);
      while (!arready);
      arvalid <= 1'b0;
      araddr  <= ~araddr;
      while (!rvalid)
         @(posedge clock);
      data = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask : read_reg

   // high byte first so the low byte comes from a fresh shadow
   task automatic read_count(output logic [15:0] cnt);
      logic [31:0] d;
      logic [1:0]  r;
      read_reg(ssq_pkg::IDX_CNT_HI, d, r);
      cnt[15:8] = d[7:0];
      read_reg(ssq_pkg::IDX_CNT_LO, d, r);
      cnt[7:0] = d[7:0];
   endtask : read_count
endmodule : ssq_host_model
`default_nettype wire

// ===== verif/ssq_port_tb_top.sv
// testbench top for the sensor sample queue port
`timescale 1ns/1ps
`default_nettype none

module ssq_port_tb_top;
   logic         clock, rstn, sample_tick, irq;
   logic [303:0] sensor_bytes;
   logic         awvalid, awready, wvalid, wready, bvalid, bready;
   logic         arvalid, arready, rvalid, rready;
   logic [9:0]   awaddr, araddr;
   logic [31:0]  wdata, rdata, d;
   logic [3:0]   wstrb;
   logic [1:0]   bresp, rresp, resp;
   logic [15:0]  cnt;
   logic [7:0]   src, aux, b, last_byte;
   logic [7:0]   q[$];
   int           failures, checks_done;

   ssq_host_model host_u (.clock(clock), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp));

   ssq_port dut_u (.CLOCK(clock), .RSTN(rstn), .SAMPLE_TICK(sample_tick),
      .SENSOR_BYTES(sensor_bytes), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_AWADDR(awaddr), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .IRQ(irq));

   // 20 MHz clock
   initial clock = 1'b0;
   always #25 clock = ~clock;

   // -----------------------------------------------------------
   // helpers
   // -----------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   task automatic wr(input logic [7:0] idx, input logic [31:0] data);
      host_u.write_reg(idx, data, resp);
      check({30'h0, resp}, {30'h0, ssq_pkg::RESP_OKAY});
   endtask : wr

   task automatic rd(input logic [7:0] idx, output logic [31:0] data);
      host_u.read_reg(idx, data, resp);
      check({30'h0, resp}, {30'h0, ssq_pkg::RESP_OKAY});
   endtask : rd

   // slave 3 bytes follow only the aux control flag
   function automatic logic keep_byte(input int i, input logic [7:0] s, input logic [7:0] a);
      if (i < ssq_pkg::ACC_END) return s[ssq_pkg::EN_ACC];
      if (i < ssq_pkg::TMP_END) return s[ssq_pkg::EN_TEMP];
      if (i < ssq_pkg::GX_END) return s[ssq_pkg::EN_XG];
      if (i < ssq_pkg::GY_END) return s[ssq_pkg::EN_YG];
      if (i < ssq_pkg::GZ_END) return s[ssq_pkg::EN_ZG];
      if (i < ssq_pkg::S0_END) return s[ssq_pkg::EN_SLV0];
      if (i < ssq_pkg::S1_END) return s[ssq_pkg::EN_SLV1];
      if (i < ssq_pkg::S2_END) return s[ssq_pkg::EN_SLV2];
      return a[ssq_pkg::AUX_SLV3];
   endfunction : keep_byte

   // reference queue: a full queue loses its oldest byte
   task automatic push_model(input logic [7:0] v);
      if (q.size() == int'(ssq_pkg::CNT_MAX))
         void'(q.pop_front());
      q.push_back(v);
   endtask : push_model

   task automatic drain();
      host_u.read_count(cnt);
      check({16'h0, cnt}, 32'(q.size()));
      while (q.size() > 0)
      begin
         rd(ssq_pkg::IDX_DATA, d);
         last_byte = q.pop_front();
         check(d, {24'h0, last_byte});
      end
      rd(ssq_pkg::IDX_DATA, d);
      check(d, {24'h0, last_byte});
      host_u.read_count(cnt);
      check({16'h0, cnt}, 32'h0);
   endtask : drain

   // watchdog sized well above the longest pass
   initial
   begin
      repeat (40000) @(posedge clock);
      failures++;
      print_verdict();
   end

   // -----------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------
   initial
   begin
      failures = 0;
      checks_done = 0;
      last_byte = 8'h00;
      rstn = 1'b0;
      sample_tick = 1'b0;
      sensor_bytes = '0;
      repeat (6) @(posedge clock);
      rstn <= 1'b1;
      void'($urandom(32'h0646));
      host_u.read_count(cnt);
      check({16'h0, cnt}, 32'h0);
      wr(ssq_pkg::IDX_CNT_HI, 32'hff);
      host_u.read_reg(8'h10, d, resp);
      check({30'h0, resp}, {30'h0, ssq_pkg::RESP_SLVERR});
      check(d, 32'h0);
      // sample walks; pass 0 has every group on but slave 3 off
      for (int k = 0; k < 4; k++)
      begin
         src = (k == 0) ? 8'hff : 8'($urandom);
         aux = {2'h0, k[0], 5'($urandom)};
         wr(ssq_pkg::IDX_SRC_EN, {24'h0, src});
         wr(ssq_pkg::IDX_AUX_CTRL, {24'h0, aux});
         rd(ssq_pkg::IDX_SRC_EN, d);
         check(d, {24'h0, src});
         for (int i = 0; i < 38; i++)
            sensor_bytes[8*i +: 8] <= 8'($urandom);
         @(posedge clock);
         sample_tick <= 1'b1;
         @(posedge clock);
         sample_tick <= 1'b0;
         repeat (42) @(posedge clock);
         for (int i = 0; i < 38; i++)
            if (keep_byte(i, src, aux))
               push_model(sensor_bytes[8*i +: 8]);
         rd(ssq_pkg::IDX_INT_STAT, d);
         check(d & 32'h2, 32'h2);
         wr(ssq_pkg::IDX_INT_STAT, 32'h3);
         drain();
      end
      // stale low byte until the high byte is read
      for (int i = 0; i < 3; i++)
      begin
         b = 8'($urandom);
         wr(ssq_pkg::IDX_DATA, {24'h0, b});
         push_model(b);
      end
      rd(ssq_pkg::IDX_CNT_LO, d);
      check(d, 32'h0);
      host_u.read_count(cnt);
      check({16'h0, cnt}, 32'h3);
      drain();
      // overflow by three bytes, flag and interrupt
      wr(ssq_pkg::IDX_INT_MASK, 32'h1);
      for (int i = 0; i < 1027; i++)
      begin
         b = 8'($urandom);
         wr(ssq_pkg::IDX_DATA, {24'h0, b});
         push_model(b);
      end
      host_u.read_count(cnt);
      check({16'h0, cnt}, {16'h0, ssq_pkg::CNT_MAX});
      rd(ssq_pkg::IDX_INT_STAT, d);
      check(d, 32'h1);
      #1 check({31'h0, irq}, 32'h1);
      wr(ssq_pkg::IDX_INT_MASK, 32'h0);
      #1 check({31'h0, irq}, 32'h0);
      wr(ssq_pkg::IDX_INT_MASK, 32'h1);
      wr(ssq_pkg::IDX_INT_STAT, 32'h1);
      #1 check({31'h0, irq}, 32'h0);
      rd(ssq_pkg::IDX_INT_STAT, d);
      check(d, 32'h0);
      drain();
      print_verdict();
   end
endmodule : ssq_port_tb_top
`default_nettype wire
